// *** verilog/abhs_pkg.sv ***
package abhs_pkg;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HIGH_LSB = 8;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam int unsigned BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    ABHS_IDLE,
    ABHS_HIGH,
    ABHS_HIGH_HOLD,
    ABHS_LOW,
    ABHS_LOW_HOLD
  } abhs_state_e;
endpackage

// *** verilog/abhs_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface abhs_link_if;
  logic [7:0] data;
  logic data_oe_n;
  logic load_strobe;
  logic high_byte_enable;
  logic low_byte_enable;
  logic send_ready;
  logic mode;
  modport converter (
    output data, data_oe_n, load_strobe, high_byte_enable, low_byte_enable,
    input send_ready, mode
  );
  modport receiver (
    input data, data_oe_n, load_strobe, high_byte_enable, low_byte_enable,
    output send_ready, mode
  );
endinterface
`default_nettype wire

// *** verilog/abhs_converter_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module abhs_converter_end (
  input wire logic mclk_i, // 10 MHz clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic [11:0] result_i, // conversion result
  input wire logic result_valid_i, // result done pulse
  output logic result_ready_o, // buffer can take a result
  output logic busy_o, // sequence in progress
  output logic overrun_o, // result dropped, sticky
  abhs_link_if.converter link // handshake link
);
  // two-entry result buffer
  logic [11:0] buf_mem [0:abhs_pkg::BUF_DEPTH-1];
  logic wr_ptr, rd_ptr;
  logic [1:0] count;
  logic buf_pop;
  logic buf_push;
  // pin synchronisers
  logic ready_s1, ready_s2, mode_s1, mode_s2, mode_d;
  logic handshake_on;
  logic demand;
  abhs_pkg::abhs_state_e state;
  logic [11:0] word;
  logic strobe_go;

  // strobe rises a clock after the enables, so latch data has settled first
  assign strobe_go = ready_s2 && (
    (state == abhs_pkg::ABHS_HIGH && link.high_byte_enable) ||
    (state == abhs_pkg::ABHS_LOW && link.low_byte_enable));

  always_ff @(posedge mclk_i) begin
    ready_s1 <= link.send_ready;
    ready_s2 <= ready_s1;
    mode_s1 <= link.mode;
    mode_s2 <= mode_s1;
    mode_d <= mode_s2;
  end

  // a result only queues while in handshake operation with mode held
  assign buf_push = result_valid_i && (count != 2'd2) && mode_s2;
  assign buf_pop = (state == abhs_pkg::ABHS_IDLE) && (count != 2'd0) && handshake_on;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (buf_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (buf_push) begin
      buf_mem[wr_ptr] <= result_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      result_ready_o <= 1'b0;
    end else begin
      result_ready_o <= (count + {1'b0, buf_push} - {1'b0, buf_pop}) != 2'd2;
    end
  end

  // receiver too slow: a result found the buffer full
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      overrun_o <= 1'b0;
    end else if (result_valid_i && mode_s2 && count == 2'd2) begin
      overrun_o <= 1'b1;
    end
  end

  // handshake entered on mode rising; left when mode low and idle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      handshake_on <= 1'b0;
    end else if (mode_s2 && !mode_d) begin
      handshake_on <= 1'b1;
    end else if (!mode_s2 && state == abhs_pkg::ABHS_IDLE && !demand) begin
      handshake_on <= 1'b0;
    end
  end

  // rising edge with no fresh result resends the last word on demand
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      demand <= 1'b0;
    end else if (mode_s2 && !mode_d) begin
      demand <= 1'b1;
    end else if (state == abhs_pkg::ABHS_IDLE && (buf_pop || demand)) begin
      demand <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      word <= abhs_pkg::RESULT_RST;
    end else if (buf_pop) begin
      word <= buf_mem[rd_ptr];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state <= abhs_pkg::ABHS_IDLE;
    end else begin
      case (state)
        abhs_pkg::ABHS_IDLE: begin
          if (buf_pop || demand) begin
            state <= abhs_pkg::ABHS_HIGH;
          end
        end
        abhs_pkg::ABHS_HIGH: begin
          if (strobe_go) begin
            state <= abhs_pkg::ABHS_HIGH_HOLD;
          end
        end
        abhs_pkg::ABHS_HIGH_HOLD: begin
          if (ready_s2 && !link.load_strobe) begin
            state <= abhs_pkg::ABHS_LOW;
          end
        end
        abhs_pkg::ABHS_LOW: begin
          if (strobe_go) begin
            state <= abhs_pkg::ABHS_LOW_HOLD;
          end
        end
        abhs_pkg::ABHS_LOW_HOLD: begin
          if (ready_s2 && !link.load_strobe) begin
            state <= abhs_pkg::ABHS_IDLE;
          end
        end
        default: begin
          state <= abhs_pkg::ABHS_IDLE;
        end
      endcase
    end
  end

  // strobe low while byte presented, rises to clock the latch;
  // falls again when receiver drops ready (byte taken)
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      link.load_strobe <= 1'b0;
    end else if (strobe_go) begin
      link.load_strobe <= 1'b1;
    end else if (!ready_s2) begin
      link.load_strobe <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      link.data <= abhs_pkg::BYTE_RST;
      link.data_oe_n <= 1'b1;
      link.high_byte_enable <= 1'b0;
      link.low_byte_enable <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state != abhs_pkg::ABHS_IDLE);
      case (state)
        abhs_pkg::ABHS_HIGH, abhs_pkg::ABHS_HIGH_HOLD: begin
          link.data <= {4'h0, word[abhs_pkg::RESULT_W-1:abhs_pkg::HIGH_LSB]};
          link.data_oe_n <= 1'b0;
          link.high_byte_enable <= 1'b1;
          link.low_byte_enable <= 1'b0;
        end
        abhs_pkg::ABHS_LOW, abhs_pkg::ABHS_LOW_HOLD: begin
          link.data <= word[abhs_pkg::BYTE_W-1:0];
          link.data_oe_n <= 1'b0;
          link.high_byte_enable <= 1'b0;
          link.low_byte_enable <= 1'b1;
        end
        default: begin
          link.data_oe_n <= 1'b1;
          link.high_byte_enable <= 1'b0;
          link.low_byte_enable <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verilog/abhs_receiver_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module abhs_receiver_end (
  input wire logic mclk_i, // 10 MHz clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic mode_i, // handshake-mode request level
  input wire logic word_ready_i, // user takes the word
  output logic [11:0] word_o, // assembled result
  output logic word_valid_o, // word held for user
  output logic mode_o, // copy of driven mode
  abhs_link_if.receiver link // handshake link
);
  logic stb_s1, stb_s2, stb_d;
  logic hbe_s1, hbe_s2, lbe_s1, lbe_s2;
  logic [7:0] dat_s1, dat_s2;
  logic [3:0] high_part;
  logic full;

  always_ff @(posedge mclk_i) begin
    stb_s1 <= link.load_strobe;
    stb_s2 <= stb_s1;
    stb_d <= stb_s2;
    hbe_s1 <= link.high_byte_enable;
    hbe_s2 <= hbe_s1;
    lbe_s1 <= link.low_byte_enable;
    lbe_s2 <= lbe_s1;
    dat_s1 <= link.data;
    dat_s2 <= dat_s1;
  end

  // latch on strobe rising edge; ready stays low until the strobe falls and no word is held
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      link.send_ready <= 1'b0;
      link.mode <= 1'b0;
      mode_o <= 1'b0;
      high_part <= 4'h0;
      word_o <= abhs_pkg::RESULT_RST;
      full <= 1'b0;
      word_valid_o <= 1'b0;
    end else begin
      link.mode <= mode_i;
      mode_o <= mode_i;
      if (stb_s2 && !stb_d) begin
        link.send_ready <= 1'b0;
        if (hbe_s2) begin
          high_part <= dat_s2[3:0];
        end else if (lbe_s2) begin
          word_o <= {high_part, dat_s2};
          full <= 1'b1;
          word_valid_o <= 1'b1;
        end
      end else if (full && word_ready_i) begin
        full <= 1'b0;
        word_valid_o <= 1'b0;
      end else if (!full && !stb_s2) begin
        link.send_ready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/abhs_link_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module abhs_link_sva (
  input wire logic mclk_i, // link clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic [7:0] data, // byte lines
  input wire logic data_oe_n, // low while driven
  input wire logic load_strobe, // byte load strobe
  input wire logic high_byte_enable, // high byte flag
  input wire logic low_byte_enable, // low byte flag
  input wire logic send_ready, // receiver ready
  input wire logic mode // handshake mode
);
  logic high_sent;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // remembers a strobed high byte so a lone low byte is caught
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || low_byte_enable) begin
      high_sent <= 1'b0;
    end else if (load_strobe && high_byte_enable) begin
      high_sent <= 1'b1;
    end
  end
  sequence strobe_seen;
    $rose(load_strobe);
  endsequence
  sequence strobe_drops;
    ##[1:40] !load_strobe;
  endsequence
  strobe_has_enable_a: assert property (load_strobe |-> (high_byte_enable || low_byte_enable))
    else $error("strobe without byte enable");
  strobe_after_enable_a: assert property (strobe_seen |-> $past(high_byte_enable || low_byte_enable))
    else $error("strobe rose before byte enable");
  strobe_ready_a: assert property (strobe_seen |-> $past(send_ready, 2))
    else $error("strobe rose without ready");
  enabled_driven_a: assert property ((high_byte_enable || low_byte_enable) |-> !data_oe_n)
    else $error("enabled byte not driven");
  data_hold_a: assert property ((load_strobe && $past(load_strobe)) |-> $stable(data))
    else $error("data moved under strobe");
  strobe_drop_a: assert property (strobe_seen |-> strobe_drops)
    else $error("strobe stuck high");
  low_on_ready_a: assert property ($rose(low_byte_enable) |-> $past(send_ready))
    else $error("low byte without ready");
  enables_exclusive_a: assert property (!(high_byte_enable && low_byte_enable))
    else $error("both byte enables high");
  low_after_high_a: assert property ($rose(low_byte_enable) |-> high_sent)
    else $error("low byte before high byte");
  link_release_a: assert property ($fell(low_byte_enable) |-> (!high_byte_enable && !load_strobe))
    else $error("link not released after low byte");
endmodule
`default_nettype wire

// *** verif/adc_byte_handshake_sequencer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_byte_handshake_sequencer_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] result_i = 12'h000;
  logic result_valid_i = 1'b0;
  logic mode_i = 1'b0;
  logic word_ready_i = 1'b0;
  logic result_ready_o, busy_o, overrun_o, word_valid_o, mode_o;
  logic [11:0] word_o;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  logic strobe_d = 1'b0;
  logic [10:0] wire_q[$];
  logic [11:0] sent_q[$];
  abhs_link_if link();
  abhs_converter_end u_abhs_converter_end (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .result_i(result_i), .result_valid_i(result_valid_i), .result_ready_o(result_ready_o),
    .busy_o(busy_o), .overrun_o(overrun_o), .link(link));
  abhs_receiver_end u_abhs_receiver_end (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .mode_i(mode_i), .word_ready_i(word_ready_i), .word_o(word_o),
    .word_valid_o(word_valid_o), .mode_o(mode_o), .link(link));
  abhs_link_sva u_abhs_link_sva (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .data(link.data),
    .data_oe_n(link.data_oe_n), .load_strobe(link.load_strobe),
    .high_byte_enable(link.high_byte_enable), .low_byte_enable(link.low_byte_enable),
    .send_ready(link.send_ready), .mode(link.mode));
  initial forever #50 mclk_i = ~mclk_i;
  // wire monitor: one entry per strobe rise, {oe_n, high, low, data}
  always @(posedge mclk_i) begin
    strobe_d <= link.load_strobe;
    if (link.load_strobe === 1'b1 && strobe_d === 1'b0) begin
      wire_q.push_back({link.data_oe_n, link.high_byte_enable, link.low_byte_enable, link.data});
    end
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask
  task automatic send(input logic [11:0] w);
    result_i = w;
    result_valid_i = 1'b1;
    tick(1);
    result_valid_i = 1'b0;
    tick(1);
  endtask
  // word and its two wire bytes; receiver keeps ready low until consumed
  task automatic get_word(input logic [11:0] w);
    int i;
    i = 0;
    while (word_valid_o !== 1'b1 && i < 300) begin
      tick(1);
      i++;
    end
    chk({4'h0, word_o}, {4'h0, w});
    chk(16'(wire_q.size()), 16'h0002);
    if (wire_q.size() >= 2) begin
      chk({5'h00, wire_q[0]}, {5'h00, 3'b010, 4'h0, w[11:8]});
      chk({5'h00, wire_q[1]}, {5'h00, 3'b001, w[7:0]});
    end
    wire_q.delete();
    word_ready_i = 1'b1;
    tick(1);
    word_ready_i = 1'b0;
    tick(1);
  endtask
  // mode rise with an empty buffer first resends the reset word
  task automatic t_auto();
    mode_i = 1'b1;
    get_word(abhs_pkg::RESULT_RST);
    send(12'ha5c);
    get_word(12'ha5c);
    send(12'h3f0);
    get_word(12'h3f0);
  endtask
  task automatic t_refuse();
    mode_i = 1'b0;
    tick(8);
    send(12'h123);
    tick(60);
    chk({15'h0000, word_valid_o}, 16'h0000);
    chk(16'(wire_q.size()), 16'h0000);
    chk({15'h0000, link.send_ready}, 16'h0001);
  endtask
  task automatic t_demand();
    mode_i = 1'b1;
    get_word(12'h3f0);
  endtask
  // receiver stalls so the buffer fills; excess result must not shift order
  task automatic t_stall();
    int i;
    i = 0;
    while (result_ready_o === 1'b1 && i < 6) begin
      sent_q.push_back(12'h800 + 12'(i));
      send(sent_q[$]);
      tick(6);
      i++;
    end
    send(12'hfff);
    chk({15'h0000, overrun_o}, 16'h0001);
    foreach (sent_q[k]) begin
      get_word(sent_q[k]);
    end
    tick(8);
    chk({15'h0000, busy_o}, 16'h0000);
    chk({15'h0000, result_ready_o}, 16'h0001);
  endtask
  initial begin
    tick(3);
    chk({10'h000, link.data_oe_n, link.load_strobe, link.high_byte_enable,
      link.low_byte_enable, word_valid_o, overrun_o}, 16'h0020);
    reset_n_i = 1'b1;
    tick(1);
    t_auto();
    t_refuse();
    t_demand();
    t_stall();
    summarize();
  end
endmodule
`default_nettype wire
